// ---- core/odcd_pkg.sv ----
// Purpose: constants shared by the eight-channel converter command decoder
// Assumes: 16-bit frames, command in the top nibble, 12-bit payload
// Notes: command codes 1101 to 1111 are passed on, not decoded here
// Summary of operation
// - Top four bits command, low twelve payload
// - Power-up in register-only mode
// - Top bit 0 writes selected holding register
// - Code 1001 selects persistent write-through mode
// - Code 1000 selects persistent register-only mode
// - Write-through channel write also updates output
// - Special commands never change stored mode
// - Code 1010 copies masked holdings to outputs
// - Code 1010 bits 11:10 select regulator
// - Code 1011 loads channel one, updates all
// - First-channel write keeps register-only mode
// - Code 1100 broadcasts payload to all
// - Shift MSB first on falling clock edges
// - Execute only on sync rise after sixteen
// - Early sync rise discards partial frame
// - Reset clears registers, register-only, regulator off
package odcd_pkg;
	localparam int FRAME_BITS = 16;
	localparam int DATA_W = 12;
	localparam int CHAN_N = 8;
	localparam int CMD_W = 4;
	localparam int CMD_HI = 15;
	localparam int CMD_LO = 12;
	localparam int SEL_HI = 11;
	localparam int SEL_LO = 10;
	localparam int MASK_HI = 7;
	localparam int MASK_LO = 0;
	localparam int CHSEL_W = 3;
	localparam logic [CMD_W-1:0] CMD_REG_ONLY = 4'h8;
	localparam logic [CMD_W-1:0] CMD_WRITE_THRU = 4'h9;
	localparam logic [CMD_W-1:0] CMD_UPDATE_SEL = 4'ha;
	localparam logic [CMD_W-1:0] CMD_FIRST_CHAN = 4'hb;
	localparam logic [CMD_W-1:0] CMD_BROADCAST = 4'hc;
	localparam logic [1:0] REG_SEL_OFF = 2'h0;
	localparam logic [1:0] REG_SEL_ON = 2'h2;
	localparam logic [DATA_W-1:0] DATA_RESET = 12'h000;
endpackage

// ---- core/odcd_sync.sv ----
// Purpose: two-flop level synchroniser bank
// Assumes: inputs are levels or toggles from another clock domain
// Notes: only the second stage leaves this module
`timescale 1ns/1ps
module odcd_sync #(
	parameter int W = 2,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} odcd_sync_st_t;

	odcd_sync_st_t s_q;
	odcd_sync_st_t s_d;

	if (W < 1) begin : g_chk
		$error("odcd_sync width must be positive");
	end

	always_comb begin
		s_d.s1 = d;
		s_d.s2 = s_q.s1;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= {RST_VAL, RST_VAL};
		end else begin
			s_q <= s_d;
		end
	end

	assign q = s_q.s2;
endmodule

// ---- core/odcd_link.sv ----
// Purpose: serial frame shifter on the link clock
// Assumes: data and frame sync change away from falling clock edges
// Notes: finished word is held until the next complete frame
`timescale 1ns/1ps
module odcd_link import odcd_pkg::*; #(
	parameter int BITS = FRAME_BITS
) (
	input wire logic link_clk,
	input wire logic nrst,
	input wire logic sync_n,
	input wire logic din,
	output logic [BITS-1:0] word,
	output logic done_tgl
);
	localparam int CNT_W = $clog2(BITS + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(BITS - 1);
	localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(BITS);

	typedef struct packed {
		logic [BITS-1:0] shift;
		logic [BITS-1:0] word;
		logic tgl;
	} odcd_link_st_t;

	odcd_link_st_t l_q;
	odcd_link_st_t l_d;
	logic [CNT_W-1:0] cnt_q;
	logic cnt_rst_n;

	if (BITS < 2) begin : g_chk
		$error("odcd_link frame must hold at least two bits");
	end

	// The link clock stops between frames, so the edge count is cleared by sync itself
	assign cnt_rst_n = nrst & ~sync_n;

	always_ff @(negedge link_clk or negedge cnt_rst_n) begin
		if (!cnt_rst_n) begin
			cnt_q <= '0;
		end else if (cnt_q != CNT_FULL) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	always_comb begin
		l_d = l_q;
		if (!sync_n) begin
			l_d.shift = {l_q.shift[BITS-2:0], din};
			if (cnt_q == CNT_LAST) begin
				l_d.word = {l_q.shift[BITS-2:0], din};
				l_d.tgl = ~l_q.tgl;
			end
		end
	end

	always_ff @(negedge link_clk or negedge nrst) begin
		if (!nrst) begin
			l_q <= '0;
		end else begin
			l_q <= l_d;
		end
	end

	assign word = l_q.word;
	assign done_tgl = l_q.tgl;
endmodule

// ---- core/odcd_top.sv ----
// Purpose: command decoder for an eight-channel 12-bit converter
// Assumes: SCLK is the host's serial clock, unrelated to CLOCK
// Notes: commands execute two CLOCK edges after the sync rise is first sampled
`timescale 1ns/1ps
module odcd_top import odcd_pkg::*; #(
	parameter int CHANNELS = CHAN_N,
	parameter int WIDTH = DATA_W
) (
	input wire logic CLOCK,
	input wire logic NRST,
	input wire logic SCLK,
	input wire logic SYNC_N,
	input wire logic DIN,
	output logic [CHANNELS-1:0][WIDTH-1:0] CHANNEL_OUT,
	output logic [CHANNELS-1:0][WIDTH-1:0] CHANNEL_HOLD,
	output logic REGULATOR_EN,
	output logic WRITE_THROUGH,
	output logic CMD_DONE,
	output logic FRAME_ABORT,
	output logic PD_STROBE,
	output logic [CMD_W-1:0] PD_CODE,
	output logic [MASK_HI:MASK_LO] PD_MASK
);
	typedef struct packed {
		logic [CHANNELS-1:0][WIDTH-1:0] hold;
		logic [CHANNELS-1:0][WIDTH-1:0] out;
		logic [FRAME_BITS-1:0] word;
		logic write_through;
		logic reg_en;
		logic pend;
		logic tgl_seen;
		logic sync_prev;
		logic done;
		logic abort;
		logic pd_strobe;
		logic [CMD_W-1:0] pd_code;
		logic [MASK_HI:MASK_LO] pd_mask;
	} odcd_state_t;

	odcd_state_t s_q;
	odcd_state_t s_d;

	logic [FRAME_BITS-1:0] link_word;
	logic link_tgl;
	logic tgl_s;
	logic sync_s;
	logic tgl_new;
	logic sync_rise;
	logic sync_fall;
	logic have_frame;
	logic exec_now;
	logic [FRAME_BITS-1:0] cur_word;
	logic [CMD_W-1:0] cmd;
	logic [DATA_W-1:0] pl;
	logic [CHSEL_W-1:0] ch_sel;
	logic [1:0] reg_sel;

	if (CHANNELS != CHAN_N || WIDTH != DATA_W) begin : g_chk
		$error("odcd_top serves exactly eight 12-bit channels");
	end

	odcd_link #(
		.BITS(FRAME_BITS)
	) u_link (
		.link_clk(SCLK),
		.nrst(NRST),
		.sync_n(SYNC_N),
		.din(DIN),
		.word(link_word),
		.done_tgl(link_tgl)
	);

	// Sync rests high, so its synchroniser resets high to avoid a false rising edge
	odcd_sync #(
		.W(2),
		.RST_VAL(2'h1)
	) u_sync (
		.clk(CLOCK),
		.nrst(NRST),
		.d({link_tgl, SYNC_N}),
		.q({tgl_s, sync_s})
	);

	always_comb begin
		tgl_new = tgl_s != s_q.tgl_seen;
		sync_rise = sync_s && !s_q.sync_prev;
		sync_fall = !sync_s && s_q.sync_prev;
		// The held link word is stable once its toggle has crossed
		cur_word = tgl_new ? link_word : s_q.word;
		have_frame = s_q.pend || tgl_new;
		exec_now = sync_rise && have_frame;
		cmd = cur_word[CMD_HI:CMD_LO];
		pl = cur_word[DATA_W-1:0];
		ch_sel = cmd[CHSEL_W-1:0];
		reg_sel = pl[SEL_HI:SEL_LO];
	end

	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		s_d.abort = 1'b0;
		s_d.pd_strobe = 1'b0;
		s_d.sync_prev = sync_s;
		s_d.tgl_seen = tgl_s;
		if (tgl_new) begin
			s_d.word = link_word;
			s_d.pend = 1'b1;
		end
		if (sync_fall) begin
			s_d.pend = 1'b0;
		end
		if (sync_rise) begin
			s_d.pend = 1'b0;
			s_d.abort = !have_frame;
		end
		if (exec_now) begin
			s_d.done = 1'b1;
			if (!cmd[CMD_W-1]) begin
				s_d.hold[ch_sel] = pl;
				if (s_q.write_through) begin
					s_d.out[ch_sel] = pl;
				end
			end else begin
				unique case (cmd)
					CMD_REG_ONLY: begin
						s_d.write_through = 1'b0;
					end
					CMD_WRITE_THRU: begin
						s_d.write_through = 1'b1;
					end
					CMD_UPDATE_SEL: begin
						for (int i = 0; i < CHANNELS; i++) begin
							if (pl[MASK_LO + i]) begin
								s_d.out[i] = s_q.hold[i];
							end
						end
						// Codes 01 and 11 leave the regulator as it was
						if (reg_sel == REG_SEL_ON) begin
							s_d.reg_en = 1'b1;
						end else if (reg_sel == REG_SEL_OFF) begin
							s_d.reg_en = 1'b0;
						end
					end
					CMD_FIRST_CHAN: begin
						s_d.out = s_q.hold;
						s_d.hold[0] = pl;
						s_d.out[0] = pl;
					end
					CMD_BROADCAST: begin
						for (int i = 0; i < CHANNELS; i++) begin
							s_d.hold[i] = pl;
							s_d.out[i] = pl;
						end
					end
					default: begin
						s_d.pd_strobe = 1'b1;
						s_d.pd_code = cmd;
						s_d.pd_mask = pl[MASK_HI:MASK_LO];
					end
				endcase
			end
		end
	end

	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			s_q <= '{hold: '0, out: '0, word: '0, write_through: 1'b0, reg_en: 1'b0,
				pend: 1'b0, tgl_seen: 1'b0, sync_prev: 1'b1, done: 1'b0, abort: 1'b0,
				pd_strobe: 1'b0, pd_code: '0, pd_mask: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign CHANNEL_OUT = s_q.out;
	assign CHANNEL_HOLD = s_q.hold;
	assign REGULATOR_EN = s_q.reg_en;
	assign WRITE_THROUGH = s_q.write_through;
	assign CMD_DONE = s_q.done;
	assign FRAME_ABORT = s_q.abort;
	assign PD_STROBE = s_q.pd_strobe;
	assign PD_CODE = s_q.pd_code;
	assign PD_MASK = s_q.pd_mask;

	// Checks on command execution

	property p_cmd_split;
		@(posedge CLOCK) disable iff (!NRST)
		exec_now && cmd == CMD_BROADCAST
		|=> CHANNEL_OUT[0] == $past(pl) && CHANNEL_HOLD[CHANNELS-1] == $past(pl);
	endproperty
	a_cmd_split: assert property (p_cmd_split) else $error("payload not taken from low twelve bits");

	property p_reg_only_write;
		@(posedge CLOCK) disable iff (!NRST)
		exec_now && !cmd[CMD_W-1] && !WRITE_THROUGH
		|=> $stable(CHANNEL_OUT) ##1 $stable(CHANNEL_OUT) || CMD_DONE;
	endproperty
	a_reg_only_write: assert property (p_reg_only_write) else $error("output moved in register-only mode");

	property p_hold_write;
		@(posedge CLOCK) disable iff (!NRST)
		exec_now && !cmd[CMD_W-1]
		|=> CHANNEL_HOLD[$past(ch_sel)] == $past(pl) && CMD_DONE;
	endproperty
	a_hold_write: assert property (p_hold_write) else $error("holding register not written");

	property p_enter_wt;
		@(posedge CLOCK) disable iff (!NRST)
		exec_now && cmd == CMD_WRITE_THRU |=> WRITE_THROUGH [*2];
	endproperty
	a_enter_wt: assert property (p_enter_wt) else $error("write-through mode not entered");

	property p_enter_ro;
		@(posedge CLOCK) disable iff (!NRST)
		exec_now && cmd == CMD_REG_ONLY |=> !WRITE_THROUGH [*2];
	endproperty
	a_enter_ro: assert property (p_enter_ro) else $error("register-only mode not entered");

	property p_wt_write;
		@(posedge CLOCK) disable iff (!NRST)
		exec_now && !cmd[CMD_W-1] && WRITE_THROUGH
		|=> CHANNEL_OUT[$past(ch_sel)] == $past(pl);
	endproperty
	a_wt_write: assert property (p_wt_write) else $error("output not written in write-through mode");

	property p_mode_kept;
		@(posedge CLOCK) disable iff (!NRST)
		!(exec_now && (cmd == CMD_REG_ONLY || cmd == CMD_WRITE_THRU)) |=> $stable(WRITE_THROUGH);
	endproperty
	a_mode_kept: assert property (p_mode_kept) else $error("mode changed by another command");

	for (genvar g = 0; g < CHANNELS; g++) begin : g_upd
		property p_update_sel;
			@(posedge CLOCK) disable iff (!NRST)
			exec_now && cmd == CMD_UPDATE_SEL
			|=> CHANNEL_OUT[g] == ($past(pl[MASK_LO + g]) ? $past(CHANNEL_HOLD[g]) : $past(CHANNEL_OUT[g]));
		endproperty
		a_update_sel: assert property (p_update_sel) else $error("update select wrong for a channel");
	end

	property p_regulator;
		@(posedge CLOCK) disable iff (!NRST)
		exec_now && cmd == CMD_UPDATE_SEL && reg_sel == REG_SEL_ON |=> REGULATOR_EN;
	endproperty
	a_regulator: assert property (p_regulator) else $error("regulator not enabled");

	property p_regulator_off;
		@(posedge CLOCK) disable iff (!NRST)
		exec_now && cmd == CMD_UPDATE_SEL && reg_sel == REG_SEL_OFF |=> !REGULATOR_EN;
	endproperty
	a_regulator_off: assert property (p_regulator_off) else $error("regulator not disabled");

	property p_first_chan;
		@(posedge CLOCK) disable iff (!NRST)
		exec_now && cmd == CMD_FIRST_CHAN
		|=> CHANNEL_OUT[0] == $past(pl) && CHANNEL_HOLD[0] == $past(pl)
			&& CHANNEL_OUT[CHANNELS-1] == $past(CHANNEL_HOLD[CHANNELS-1]);
	endproperty
	a_first_chan: assert property (p_first_chan) else $error("first-channel write wrong");

	property p_first_chan_mode;
		@(posedge CLOCK) disable iff (!NRST)
		exec_now && cmd == CMD_FIRST_CHAN && !WRITE_THROUGH |=> !WRITE_THROUGH;
	endproperty
	a_first_chan_mode: assert property (p_first_chan_mode) else $error("first-channel write left register-only");

	property p_broadcast;
		@(posedge CLOCK) disable iff (!NRST)
		exec_now && cmd == CMD_BROADCAST
		|=> CHANNEL_OUT[3] == $past(pl) && CHANNEL_HOLD[5] == $past(pl) && CHANNEL_OUT[7] == CHANNEL_HOLD[7];
	endproperty
	a_broadcast: assert property (p_broadcast) else $error("broadcast did not reach all channels");

	property p_exec_on_rise;
		@(posedge CLOCK) disable iff (!NRST)
		CMD_DONE |-> $past(sync_s) && !$past(s_q.sync_prev);
	endproperty
	a_exec_on_rise: assert property (p_exec_on_rise) else $error("command executed without sync rise");

	property p_abort;
		@(posedge CLOCK) disable iff (!NRST)
		sync_rise && !have_frame
		|=> FRAME_ABORT && !CMD_DONE && $stable(CHANNEL_OUT) && $stable(CHANNEL_HOLD);
	endproperty
	a_abort: assert property (p_abort) else $error("partial frame was not discarded");

	property p_pd_pass;
		@(posedge CLOCK) disable iff (!NRST)
		exec_now && cmd > CMD_BROADCAST |=> PD_STROBE && PD_CODE == $past(cmd) && $stable(CHANNEL_OUT);
	endproperty
	a_pd_pass: assert property (p_pd_pass) else $error("power-down command not handed over");

	property p_pd_mask;
		@(posedge CLOCK) disable iff (!NRST)
		exec_now && cmd > CMD_BROADCAST
		|=> PD_MASK == $past(pl[MASK_HI:MASK_LO]) && $stable(CHANNEL_HOLD) && $stable(WRITE_THROUGH);
	endproperty
	a_pd_mask: assert property (p_pd_mask) else $error("power-down channel mask not handed over");

	property p_pd_quiet;
		@(posedge CLOCK) disable iff (!NRST)
		!(exec_now && cmd > CMD_BROADCAST) |=> !PD_STROBE;
	endproperty
	a_pd_quiet: assert property (p_pd_quiet) else $error("power-down strobe without its command");

	property p_idle_quiet;
		@(posedge CLOCK) disable iff (!NRST)
		!exec_now
		|=> !CMD_DONE && $stable(CHANNEL_OUT) && $stable(CHANNEL_HOLD) && $stable(REGULATOR_EN);
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("state moved without an executed frame");

	property p_reg_unchanged;
		@(posedge CLOCK) disable iff (!NRST)
		exec_now && cmd == CMD_UPDATE_SEL && reg_sel[0] |=> $stable(REGULATOR_EN);
	endproperty
	a_reg_unchanged: assert property (p_reg_unchanged) else $error("reserved regulator code changed it");

	property p_special_keeps_mode;
		@(posedge CLOCK) disable iff (!NRST)
		exec_now && cmd[CMD_W-1] && cmd != CMD_REG_ONLY && cmd != CMD_WRITE_THRU
		|=> $stable(WRITE_THROUGH);
	endproperty
	a_special_keeps_mode: assert property (p_special_keeps_mode) else $error("special command changed mode");

	for (genvar g = 1; g < CHANNELS; g++) begin : g_fc
		property p_first_chan_rest;
			@(posedge CLOCK) disable iff (!NRST)
			exec_now && cmd == CMD_FIRST_CHAN |=> CHANNEL_OUT[g] == $past(CHANNEL_HOLD[g]);
		endproperty
		a_first_chan_rest: assert property (p_first_chan_rest) else $error("channel not updated");
	end

	for (genvar g = 0; g < CHANNELS; g++) begin : g_bc
		property p_broadcast_all;
			@(posedge CLOCK) disable iff (!NRST)
			exec_now && cmd == CMD_BROADCAST |=> CHANNEL_OUT[g] == $past(pl) && CHANNEL_HOLD[g] == $past(pl);
		endproperty
		a_broadcast_all: assert property (p_broadcast_all) else $error("broadcast missed a channel");
	end

	// Guards against a decode that writes more than the addressed channel
	for (genvar g = 0; g < CHANNELS; g++) begin : g_ho
		property p_hold_other;
			@(posedge CLOCK) disable iff (!NRST)
			exec_now && !cmd[CMD_W-1] && ch_sel != CHSEL_W'(g)
			|=> $stable(CHANNEL_HOLD[g]) && $stable(CHANNEL_OUT[g]);
		endproperty
		a_hold_other: assert property (p_hold_other) else $error("channel write touched another channel");
	end
endmodule

// ---- verification/odcd_host.sv ----
// Purpose: serial host model driving frames into the command decoder
// Assumes: link clock of 30 ns period, running only inside a frame
// Notes: data idles at the inverse of its last bit so a stale value is never mistaken for a live one
`timescale 1ns/1ps
module odcd_host (
	output logic sclk,
	output logic sync_n,
	output logic din
);
	initial begin
		sclk = 1'b1;
		sync_n = 1'b1;
		din = 1'b0;
	end
	// Sends the first n bits of w, top bit first, data moved on the rising edge
	task automatic send(input logic [15:0] w, input int n);
		sync_n = 1'b0;
		#15;
		for (int i = 0; i < n; i++) begin
			din = w[15 - (i % 16)];
			#15 sclk = 1'b0;
			#15 sclk = 1'b1;
		end
		// Last fall well ahead of the sync rise, as the decoder needs two system clocks
		#100 sync_n = 1'b1;
		din = ~din;
	endtask
endmodule

// ---- verification/odcd_top_tb.sv ----
// Purpose: self-checking bench for the converter command decoder
// Assumes: outputs settle within eight system clocks of the sync rise
// Notes: expected state is kept in a small model updated per frame
`timescale 1ns/1ps
module odcd_top_tb;
	import odcd_pkg::*;
	logic clk;
	logic nrst;
	logic sclk;
	logic sync_n;
	logic din;
	logic [CHAN_N-1:0][DATA_W-1:0] ch_out;
	logic [CHAN_N-1:0][DATA_W-1:0] ch_hold;
	logic reg_en;
	logic wt;
	logic cmd_done;
	logic frame_abort;
	logic pd_strobe;
	logic [CMD_W-1:0] pd_code;
	logic [7:0] pd_mask;
	logic [DATA_W-1:0] e_hold [CHAN_N];
	logic [DATA_W-1:0] e_out [CHAN_N];
	logic e_wt;
	logic e_reg;
	logic [CMD_W-1:0] e_code;
	logic [7:0] e_mask;
	int n_errors;
	int compares;

	odcd_host i_host (.sclk(sclk), .sync_n(sync_n), .din(din));
	odcd_top i_dut (.CLOCK(clk), .NRST(nrst), .SCLK(sclk), .SYNC_N(sync_n), .DIN(din),
		.CHANNEL_OUT(ch_out), .CHANNEL_HOLD(ch_hold), .REGULATOR_EN(reg_en), .WRITE_THROUGH(wt),
		.CMD_DONE(cmd_done), .FRAME_ABORT(frame_abort), .PD_STROBE(pd_strobe),
		.PD_CODE(pd_code), .PD_MASK(pd_mask));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic report_and_stop();
		$display("Counts: %0d compares, %0d errors", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic model_clear();
		for (int i = 0; i < CHAN_N; i++) begin
			e_hold[i] = DATA_RESET;
			e_out[i] = DATA_RESET;
		end
		e_wt = 1'b0;
		e_reg = 1'b0;
		e_code = '0;
		e_mask = '0;
	endtask

	task automatic check_all(input string tname);
		for (int i = 0; i < CHAN_N; i++) begin
			check("hold", {4'h0, ch_hold[i]}, {4'h0, e_hold[i]});
			check("out", {4'h0, ch_out[i]}, {4'h0, e_out[i]});
		end
		check("write_through", {15'h0, wt}, {15'h0, e_wt});
		check("regulator", {15'h0, reg_en}, {15'h0, e_reg});
		check("pd_code", {12'h0, pd_code}, {12'h0, e_code});
		check("pd_mask", {8'h0, pd_mask}, {8'h0, e_mask});
		$display("Test %s done", tname);
	endtask

	task automatic model_apply(input logic [15:0] w);
		logic [3:0] c;
		logic [DATA_W-1:0] p;
		c = w[15:12];
		p = w[11:0];
		if (!c[3]) begin
			e_hold[c[2:0]] = p;
			if (e_wt) e_out[c[2:0]] = p;
		end else if (c == CMD_REG_ONLY) begin
			e_wt = 1'b0;
		end else if (c == CMD_WRITE_THRU) begin
			e_wt = 1'b1;
		end else if (c == CMD_UPDATE_SEL) begin
			for (int i = 0; i < CHAN_N; i++) if (w[i]) e_out[i] = e_hold[i];
			if (w[11:10] == REG_SEL_ON) e_reg = 1'b1;
			if (w[11:10] == REG_SEL_OFF) e_reg = 1'b0;
		end else if (c == CMD_FIRST_CHAN) begin
			for (int i = 1; i < CHAN_N; i++) e_out[i] = e_hold[i];
			e_hold[0] = p;
			e_out[0] = p;
		end else if (c == CMD_BROADCAST) begin
			for (int i = 0; i < CHAN_N; i++) begin
				e_hold[i] = p;
				e_out[i] = p;
			end
		end else begin
			e_code = c;
			e_mask = w[7:0];
		end
	endtask

	// One frame of n link edges; a complete frame executes, anything short is dropped
	task automatic frame(input logic [15:0] w, input int n);
		logic [15:0] got;
		logic [15:0] pd_seen;
		got = 16'h0;
		pd_seen = 16'h0;
		i_host.send(w, n);
		for (int k = 0; k < 8 && got == 16'h0; k++) begin
			@(negedge clk);
			if (pd_strobe === 1'b1) pd_seen = 16'h1;
			if (cmd_done === 1'b1) got = 16'h1;
			if (frame_abort === 1'b1) got = 16'h2;
		end
		if (got == 16'h0) begin
			n_errors++;
			$display("Error frame_answer expected pulse seen none");
			report_and_stop();
		end
		check("answer", got, (n == FRAME_BITS) ? 16'h1 : 16'h2);
		check("pd_strobe", pd_seen, {15'h0, n == FRAME_BITS && w[15:12] > CMD_BROADCAST});
		if (n == FRAME_BITS) model_apply(w);
		repeat (6) @(negedge clk);
	endtask

	task automatic do_reset();
		nrst = 1'b0;
		repeat (16) @(negedge clk);
		model_clear();
		check_all("reset");
		nrst = 1'b1;
		repeat (4) @(negedge clk);
	endtask

	initial begin
		n_errors = 0;
		compares = 0;
		nrst = 1'b0;
		do_reset();
		for (int ch = 0; ch < CHAN_N; ch++) frame({1'b0, ch[2:0], 12'ha50 ^ (ch[11:0] * 12'h111)}, 16);
		check_all("register_only_writes");
		frame({CMD_UPDATE_SEL, 4'h8, 8'h5a}, 16);
		check_all("update_select_on");
		frame({CMD_UPDATE_SEL, 4'h4, 8'h81}, 16);
		frame({CMD_UPDATE_SEL, 4'h0, 8'h00}, 16);
		check_all("update_select_off");
		frame({CMD_WRITE_THRU, 12'h000}, 16);
		frame({4'h3, 12'hfff}, 16);
		check_all("write_through");
		frame({CMD_BROADCAST, 12'h7ff}, 16);
		frame({4'h6, 12'h001}, 16);
		check_all("broadcast_keeps_mode");
		frame({CMD_REG_ONLY, 12'h000}, 16);
		frame({4'h7, 12'h9c3}, 16);
		frame({4'h2, 12'h456}, 16);
		check_all("register_only_again");
		frame({CMD_FIRST_CHAN, 12'h123}, 16);
		check_all("first_channel");
		frame({4'h1, 12'hbad}, 14);
		frame({CMD_BROADCAST, 12'h000}, 15);
		check_all("aborted_frames");
		frame({4'hd, 4'hf, 8'h3c}, 16);
		frame({4'he, 4'h0, 8'h18}, 16);
		frame({4'hf, 4'h0, 8'hc1}, 16);
		check_all("power_down_handoff");
		frame({CMD_WRITE_THRU, 12'h000}, 16);
		frame({CMD_UPDATE_SEL, 4'h8, 8'h00}, 16);
		do_reset();
		frame({4'h5, 12'h0f0}, 16);
		check_all("after_second_reset");
		report_and_stop();
	end
endmodule
